// ===== sim/adm_far_end.sv
// Far-end stand-in for layer 1 activation control and the layer 2 entities.
// Assumes the bench calls its tasks and that pclk is the monitor's clock.
`timescale 1ns/1ps
module adm_far_end (
   // Clock
   input  wire logic            pclk,
   // Toward the monitor
   output adm_pkg::adm_l2_ind_s l2_ind,
   output adm_pkg::adm_l1_ind_s l1_ind,
   // From the monitor
   input  wire logic            deact_req
);
   import adm_pkg::*;
   int deact_heard;
   // ===================
   // Indications
   initial begin
      l2_ind = '0;
      l1_ind = '0;
      deact_heard = 0;
   end
   // One pulse per establish, release or UI primitive
   // Links are released after each acknowledged transfer, so free follows use
   task automatic l2_pulse(input adm_l2_ind_s v);
      @(posedge pclk);
      l2_ind <= v;
      @(posedge pclk);
      l2_ind <= '0;
   endtask
   task automatic l1_pulse(input adm_l1_ind_s v);
      @(posedge pclk);
      l1_ind <= v;
      @(posedge pclk);
      l1_ind <= '0;
   endtask
   // ===================
   // Requests
   // Layer 1 obeys silently; no indication is echoed, the bench decides
   always @(negedge pclk) begin
      if (deact_req === 1'b1) begin
         deact_heard++;
      end
   end
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the access deactivation monitor.
// Assumes the far-end model drives the indications; timer shortened to 20 cycles.
`timescale 1ns/1ps
`include "adm_defs.svh"
module tb_top;
   import adm_pkg::*;
   localparam int TB_TICK  = 4;
   localparam int TB_INACT = 5;
   localparam int TMR      = TB_TICK * TB_INACT;
   localparam adm_l2_ind_s free_ev = 3'b100;
   localparam adm_l2_ind_s use_ev  = 3'b010;
   localparam adm_l2_ind_s ud_ev   = 3'b001;
   localparam adm_l1_ind_s act_ev  = 2'b10;
   localparam adm_l1_ind_s dea_ev  = 2'b01;
   logic                   pclk;
   logic                   presetn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [`ADM_ADDR_W-1:0] paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   deact_req;
   adm_l2_ind_s            l2_ind;
   adm_l1_ind_s            l1_ind;
   int                     err_total;
   int                     checked;
   logic [31:0]            rd;
   logic                   er;

   adm_monitor #(.TICK_CYC(TB_TICK), .INACT_TICKS(TB_INACT)) u_adm_monitor (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .l2_ind(l2_ind), .l1_ind(l1_ind), .deact_req(deact_req));
   adm_far_end u_adm_far_end (
      .pclk(pclk), .l2_ind(l2_ind), .l1_ind(l1_ind), .deact_req(deact_req));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ===================
   // Helpers
   task automatic tally_and_finish();
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         tally_and_finish();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // Expects exactly one one-cycle request, not sooner than lo cycles;
   // the far end's count is read a cycle later so its own sampling has settled
   task automatic expect_deact(input int lo, input int hi);
      int n;
      int c0;
      c0 = u_adm_far_end.deact_heard;
      n = 0;
      while (deact_req !== 1'b1 && n < hi) begin
         @(negedge pclk);
         n++;
      end
      if (deact_req !== 1'b1) begin
         err_total++;
         tally_and_finish();
      end
      if (n < lo) chk(n, lo);
      @(negedge pclk);
      chk({31'h0, deact_req}, 32'h0);
      chk(u_adm_far_end.deact_heard, c0 + 1);
   endtask

   // ===================
   // Scenarios
   task automatic t_regs();
      rd_chk(`ADM_CTRL_OFS, 32'h3);
      rd_chk(`ADM_STAT_OFS, 32'h1);
      rd_chk(`ADM_CNT_OFS, 32'h0);
      apb(1'b1, `ADM_STAT_OFS, 32'hff);
      rd_chk(`ADM_STAT_OFS, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic t_expire();
      u_adm_far_end.l1_pulse(act_ev);
      rd_chk(`ADM_STAT_OFS, 32'ha);
      expect_deact(TMR - 6, TMR + 10);
      rd_chk(`ADM_STAT_OFS, 32'h1);
      rd_chk(`ADM_CNT_OFS, 32'h1);
   endtask
   task automatic t_unit_data();
      u_adm_far_end.l1_pulse(act_ev);
      repeat (12) @(posedge pclk);
      u_adm_far_end.l2_pulse(ud_ev);
      expect_deact(TMR - 6, TMR + 10);
   endtask
   task automatic t_disabled();
      int c0;
      apb(1'b1, `ADM_CTRL_OFS, 32'h2);
      c0 = u_adm_far_end.deact_heard;
      u_adm_far_end.l1_pulse(act_ev);
      repeat (2 * TMR + 10) @(posedge pclk);
      chk(u_adm_far_end.deact_heard, c0);
      rd_chk(`ADM_STAT_OFS, 32'ha);
      u_adm_far_end.l2_pulse(use_ev);
      rd_chk(`ADM_STAT_OFS, 32'h3);
      u_adm_far_end.l1_pulse(dea_ev);
      rd_chk(`ADM_STAT_OFS, 32'h6);
      u_adm_far_end.l2_pulse(free_ev);
      rd_chk(`ADM_STAT_OFS, 32'hd);
      apb(1'b1, `ADM_CTRL_OFS, 32'h3);
      expect_deact(4, TMR + 10);
      rd_chk(`ADM_CNT_OFS, 32'h3);
   endtask
   task automatic t_paths();
      u_adm_far_end.l2_pulse(use_ev);
      u_adm_far_end.l2_pulse(free_ev);
      rd_chk(`ADM_STAT_OFS, 32'h1);
      u_adm_far_end.l2_pulse(use_ev);
      rd_chk(`ADM_STAT_OFS, 32'h4);
      u_adm_far_end.l1_pulse(act_ev);
      rd_chk(`ADM_STAT_OFS, 32'h3);
      u_adm_far_end.l2_pulse(free_ev);
      rd_chk(`ADM_STAT_OFS, 32'ha);
      u_adm_far_end.l1_pulse(dea_ev);
      rd_chk(`ADM_STAT_OFS, 32'hd);
      u_adm_far_end.l2_pulse(use_ev);
      rd_chk(`ADM_STAT_OFS, 32'h6);
      u_adm_far_end.l1_pulse(act_ev);
      rd_chk(`ADM_STAT_OFS, 32'h3);
      u_adm_far_end.l1_pulse(dea_ev);
      u_adm_far_end.l2_pulse(free_ev);
      u_adm_far_end.l1_pulse(act_ev);
      rd_chk(`ADM_STAT_OFS, 32'ha);
      expect_deact(TMR - 8, TMR + 10);
   endtask
   task automatic t_four();
      apb(1'b1, `ADM_CTRL_OFS, 32'h1);
      u_adm_far_end.l1_pulse(act_ev);
      u_adm_far_end.l1_pulse(dea_ev);
      rd_chk(`ADM_STAT_OFS, 32'ha);
      u_adm_far_end.l2_pulse(use_ev);
      u_adm_far_end.l1_pulse(dea_ev);
      rd_chk(`ADM_STAT_OFS, 32'h3);
      u_adm_far_end.l2_pulse(free_ev);
      expect_deact(TMR - 8, TMR + 10);
      rd_chk(`ADM_STAT_OFS, 32'h1);
   endtask
   task automatic t_reset_mid();
      u_adm_far_end.l1_pulse(act_ev);
      do_reset();
      rd_chk(`ADM_STAT_OFS, 32'h1);
      rd_chk(`ADM_CTRL_OFS, 32'h3);
      rd_chk(`ADM_CNT_OFS, 32'h0);
   endtask

   initial begin
      err_total = 0;
      checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      do_reset();
      t_regs();
      t_expire();
      t_unit_data();
      t_disabled();
      t_paths();
      t_four();
      t_reset_mid();
      tally_and_finish();
   end
endmodule

// ===== src/adm_defs.svh
// Constants of the access deactivation monitor: offsets, fields, resets, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register window.
`ifndef ADM_DEFS_SVH
`define ADM_DEFS_SVH

// ==========================================================================
// Timing
`define ADM_CLK_PERIOD_NS 10
`define ADM_TICK_NS       1000000
`define ADM_TICK_CYC      (`ADM_TICK_NS / `ADM_CLK_PERIOD_NS)
`define ADM_INACT_S       10
`define ADM_INACT_TICKS   (`ADM_INACT_S * 1000)

// ==========================================================================
// Register map (byte addresses)
`define ADM_ADDR_W        12
`define ADM_CTRL_OFS      12'h000
`define ADM_STAT_OFS      12'h004
`define ADM_CNT_OFS       12'h008

// ==========================================================================
// Fields and reset values
`define ADM_CTRL_EN_BIT   0
`define ADM_CTRL_SIX_BIT  1
`define ADM_CTRL_RST      2'h3
`define ADM_STAT_TMR_BIT  3
`define ADM_CNT_W         16

`endif

// ===== src/adm_inact_timer.sv
// Inactivity timer counting prescaler ticks; start also restarts it.
// Assumes start and stop never come together from the monitor.
`timescale 1ns/1ps
module adm_inact_timer #(
   parameter int TICK_CYC    = 100000,
   parameter int INACT_TICKS = 10000
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Commands
   input  wire logic start,
   input  wire logic stop,
   // Status
   output logic      running,
   output logic      expire
);
   localparam int TW = $clog2(INACT_TICKS + 1);

   typedef struct packed {
      logic          running;
      logic [TW-1:0] cnt;
      logic          expire;
   } adm_tmr_st_s;

   adm_tmr_st_s st_ff;
   adm_tmr_st_s nxt_st;
   logic        tick;

   // Restart also realigns the prescaler so every run lasts the full time
   adm_tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (start),
      .tick    (tick)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.expire = 1'b0;
      if (start) begin
         nxt_st.running = 1'b1;
         nxt_st.cnt = '0;
      end else if (stop) begin
         nxt_st.running = 1'b0;
         nxt_st.cnt = '0;
      end else if (st_ff.running && tick) begin
         if (st_ff.cnt == TW'(INACT_TICKS - 1)) begin
            nxt_st.running = 1'b0;
            nxt_st.cnt = '0;
            nxt_st.expire = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + TW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign running = st_ff.running;
   assign expire = st_ff.expire;

   expire_count_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.expire |-> $past(st_ff.running) && $past(st_ff.cnt) == TW'(INACT_TICKS - 1))
      else $error("timer expired before full count");
endmodule

// ===== src/adm_monitor.sv
// Network-side access deactivation monitor with APB register access.
// Assumes layer 1 and layer 2 indications are one-cycle pulses on pclk.
`timescale 1ns/1ps
`include "adm_defs.svh"
module adm_monitor #(
   parameter int TICK_CYC    = `ADM_TICK_CYC,
   parameter int INACT_TICKS = `ADM_INACT_TICKS
) (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`ADM_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Layer 2 activity, one pulse per establish, release or UI primitive
   input  wire adm_pkg::adm_l2_ind_s     l2_ind,
   // Layer 1 indications and request
   input  wire adm_pkg::adm_l1_ind_s     l1_ind,
   output logic                          deact_req
);
   import adm_pkg::*;

   adm_mon_st_s st_ff;
   adm_mon_st_s nxt_st;
   logic        tmr_start;
   logic        tmr_stop;
   logic        tmr_running;
   logic        tmr_expire;
   logic        wr_acc;
   logic        rd_setup;

   // =======================================================================
   // Inactivity timer
   adm_inact_timer #(
      .TICK_CYC    (TICK_CYC),
      .INACT_TICKS (INACT_TICKS)
   ) u_inactivity_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (tmr_start),
      .stop    (tmr_stop),
      .running (tmr_running),
      .expire  (tmr_expire)
   );

   // =======================================================================
   // Helpers
   function automatic logic [2:0] state_code(input adm_state_e s);
      logic [2:0] c;
      c = 3'h0;
      case (s)
         adm_st1: c = 3'h1;
         adm_st2: c = 3'h2;
         adm_st3: c = 3'h3;
         adm_st4: c = 3'h4;
         adm_st5: c = 3'h5;
         adm_st6: c = 3'h6;
         default: c = 3'h0;
      endcase
      return c;
   endfunction

   assign wr_acc = psel && penable && st_ff.pready && pwrite;
   assign rd_setup = psel && !penable;

   // =======================================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.deact_req = 1'b0;
      tmr_start = 1'b0;
      tmr_stop = 1'b0;

      // Bus: answer is prepared in setup so access completes with no wait
      nxt_st.pready = rd_setup;
      nxt_st.pslverr = 1'b0;
      if (rd_setup) begin
         nxt_st.prdata = 32'h0;
         case (paddr)
            `ADM_CTRL_OFS: begin
               nxt_st.prdata[`ADM_CTRL_EN_BIT] = st_ff.en;
               nxt_st.prdata[`ADM_CTRL_SIX_BIT] = st_ff.six;
            end
            `ADM_STAT_OFS: begin
               nxt_st.prdata[2:0] = state_code(st_ff.state);
               nxt_st.prdata[`ADM_STAT_TMR_BIT] = tmr_running;
            end
            `ADM_CNT_OFS: begin
               nxt_st.prdata[`ADM_CNT_W-1:0] = st_ff.deact_cnt;
            end
            default: begin
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end else begin
         // Idle bus reads zero so stale register contents never linger
         nxt_st.prdata = 32'h0;
      end
      if (wr_acc && paddr == `ADM_CTRL_OFS) begin
         nxt_st.en = pwdata[`ADM_CTRL_EN_BIT];
         nxt_st.six = pwdata[`ADM_CTRL_SIX_BIT];
      end

      // Monitor: in-use (states 1, 2, 5) or free (states 3, 4, 6) outranks layer 1 and timer events
      case (st_ff.state)
         adm_st1: begin
            if (l2_ind.in_use) begin
               nxt_st.state = adm_st4;
            end else if (l1_ind.act) begin
               nxt_st.state = adm_st2;
               tmr_start = 1'b1;
            end
         end
         adm_st2, adm_st5: begin
            if (l2_ind.in_use) begin
               nxt_st.state = (st_ff.state == adm_st2) ? adm_st3 : adm_st6;
               tmr_stop = 1'b1;
            end else begin
               if (st_ff.state == adm_st2 && st_ff.six && l1_ind.deact) begin
                  nxt_st.state = adm_st5;
               end
               if (st_ff.state == adm_st5 && l1_ind.act) begin
                  nxt_st.state = adm_st2;
               end
               if (l2_ind.unit_data) begin
                  tmr_start = 1'b1;
               end else if (tmr_expire) begin
                  if (st_ff.en) begin
                     nxt_st.deact_req = 1'b1;
                     nxt_st.state = adm_st1;
                     tmr_stop = 1'b1;
                  end else begin
                     tmr_start = 1'b1;
                  end
               end
            end
         end
         adm_st3: begin
            if (l2_ind.free) begin
               nxt_st.state = adm_st2;
               tmr_start = 1'b1;
            end else if (st_ff.six && l1_ind.deact) begin
               nxt_st.state = adm_st6;
            end
         end
         adm_st4: begin
            if (l2_ind.free) begin
               nxt_st.state = adm_st1;
            end else if (l1_ind.act) begin
               nxt_st.state = adm_st3;
            end
         end
         adm_st6: begin
            if (l2_ind.free) begin
               nxt_st.state = adm_st5;
               tmr_start = 1'b1;
            end else if (l1_ind.act) begin
               nxt_st.state = adm_st3;
            end
         end
         default: begin
            nxt_st.state = adm_st1;
            tmr_stop = 1'b1;
         end
      endcase

      // Counter saturates rather than wraps so software never misreads a burst
      if (nxt_st.deact_req && st_ff.deact_cnt != 16'hffff) begin
         nxt_st.deact_cnt = st_ff.deact_cnt + 16'h0001;
      end
   end

   // =======================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.state <= adm_st1;
         st_ff.en <= 1'((`ADM_CTRL_RST >> `ADM_CTRL_EN_BIT) & 2'h1);
         st_ff.six <= 1'((`ADM_CTRL_RST >> `ADM_CTRL_SIX_BIT) & 2'h1);
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign deact_req = st_ff.deact_req;

   // =======================================================================
   // Checks
   s1_activate_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st1 && l1_ind.act && !l2_ind.in_use
      |=> st_ff.state == adm_st2 && tmr_running)
      else $error("activation in state 1 did not start timer in state 2");

   s3_free_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st3 && l2_ind.free && !l2_ind.in_use
      |=> st_ff.state == adm_st2 && tmr_running)
      else $error("free in state 3 did not reach state 2");

   s6_free_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st6 && l2_ind.free && !l2_ind.in_use
      |=> st_ff.state == adm_st5 && tmr_running)
      else $error("free in state 6 did not reach state 5");

   expiry_deact_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state inside {adm_st2, adm_st5} && tmr_expire && st_ff.en
      && !l2_ind.in_use && !l2_ind.unit_data
      |=> deact_req && st_ff.state == adm_st1 ##1 !deact_req)
      else $error("enabled expiry did not issue a single deactivate request");

   expiry_restart_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state inside {adm_st2, adm_st5} && tmr_expire && !st_ff.en
      && !l2_ind.in_use
      |=> !deact_req && tmr_running && st_ff.state != adm_st1)
      else $error("disabled expiry did not restart the timer");

   unit_restart_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state inside {adm_st2, adm_st5} && l2_ind.unit_data && !l2_ind.in_use
      |=> tmr_running && !deact_req)
      else $error("unit data did not restart the timer");

   in_use_stop_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st2 && l2_ind.in_use
      |=> st_ff.state == adm_st3 && !tmr_running)
      else $error("in-use in state 2 did not stop the timer");

   deact_ind_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st2 && st_ff.six && l1_ind.deact && tmr_running
      && !l2_ind.in_use && !tmr_expire && !l2_ind.unit_data
      |=> st_ff.state == adm_st5 && (tmr_running || tmr_expire))
      else $error("deactivate indication did not move state 2 to 5");

   early_in_use_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st1 && l2_ind.in_use |=> st_ff.state == adm_st4)
      else $error("early in-use did not reach state 4");

   four_state_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.six && st_ff.state inside {adm_st1, adm_st2, adm_st3, adm_st4}
      |=> st_ff.state inside {adm_st1, adm_st2, adm_st3, adm_st4})
      else $error("four-state variant entered an interrupted state");

   apb_ready_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("APB access phase not answered in one cycle");

   s5_in_use_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st5 && l2_ind.in_use
      |=> st_ff.state == adm_st6 && !tmr_running)
      else $error("in-use in state 5 did not stop the timer");

   s3_deact_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st3 && st_ff.six && l1_ind.deact && !l2_ind.free
      |=> st_ff.state == adm_st6)
      else $error("deactivate indication did not move state 3 to 6");

   four_deact_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      !st_ff.six && st_ff.state == adm_st2 && l1_ind.deact
      && !l2_ind.in_use && !tmr_expire
      |=> st_ff.state == adm_st2)
      else $error("four-state variant acted on a deactivate indication");

   s4_activate_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st4 && l1_ind.act && !l2_ind.free
      |=> st_ff.state == adm_st3 && !tmr_running)
      else $error("activation in state 4 did not reach state 3");

   deact_count_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      deact_req && $past(st_ff.deact_cnt) != 16'hffff
      |-> st_ff.deact_cnt == $past(st_ff.deact_cnt) + 16'h0001)
      else $error("deactivate count did not follow the request");

   ctrl_write_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == `ADM_CTRL_OFS
      |=> st_ff.en == $past(pwdata[`ADM_CTRL_EN_BIT])
      && st_ff.six == $past(pwdata[`ADM_CTRL_SIX_BIT]))
      else $error("control write did not take effect");

   apb_unmapped_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !(paddr inside {`ADM_CTRL_OFS, `ADM_STAT_OFS, `ADM_CNT_OFS})
      |=> pslverr && prdata == 32'h0)
      else $error("unmapped address was not refused");

   deact_cover_c:
   cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st2 ##[1:1000] deact_req);

   interrupted_cover_c:
   cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st6 ##[1:100] st_ff.state == adm_st5);

   restart_cover_c:
   cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.state == adm_st2 && tmr_expire && !st_ff.en);

   four_state_cover_c:
   cover property (@(posedge pclk) disable iff (!presetn)
      !st_ff.six && st_ff.state == adm_st2 && l1_ind.deact);

   unit_data_cover_c:
   cover property (@(posedge pclk) disable iff (!presetn)
      st_ff.state inside {adm_st2, adm_st5} && l2_ind.unit_data);
endmodule

// ===== src/adm_pkg.sv
// Types of the access deactivation monitor.
// Assumes the constants header is compiled alongside.
package adm_pkg;

   // =======================================================================
   // Indication carriers
   typedef struct packed {
      logic free;
      logic in_use;
      logic unit_data;
   } adm_l2_ind_s;

   typedef struct packed {
      logic act;
      logic deact;
   } adm_l1_ind_s;

   // =======================================================================
   // Monitor states
   typedef enum logic [2:0] {
      adm_st1, adm_st2, adm_st3, adm_st4, adm_st5, adm_st6
   } adm_state_e;

   typedef struct packed {
      adm_state_e  state;
      logic        deact_req;
      logic [15:0] deact_cnt;
      logic        en;
      logic        six;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } adm_mon_st_s;

endpackage

// ===== src/adm_tick_gen.sv
// Prescaler producing one pulse every TICK_CYC clock cycles.
// Assumes clr comes from logic on pclk; clr restarts the period.
`timescale 1ns/1ps
module adm_tick_gen #(
   parameter int TICK_CYC = 100000
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Control
   input  wire logic clr,
   output logic      tick
);
   localparam int CW = $clog2(TICK_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } adm_tick_st_s;

   adm_tick_st_s st_ff;
   adm_tick_st_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (clr) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == CW'(TICK_CYC - 1)) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;

   tick_period_a:
   assert property (@(posedge pclk) disable iff (!presetn)
      st_ff.tick |-> $past(st_ff.cnt) == CW'(TICK_CYC - 1))
      else $error("prescaler tick off period");
endmodule
